// ===== logic/host_port_device.sv
`include "host_port_regs.svh"

// What this block does
// - Data strobe at address strobe picks style.
// - Address strobe fall latches address, strobe, select.
// - Selected only when select low at latch.
// - High style: drive bus while strobe low.
// - High style: write data taken as rw rises.
// - Low style: rw decides bus direction.
// - Low style: strobe high writes or reads.
// - Read/write line picks register write or read.
// - Eight shared host address/data lines.
// - Memory low byte: address then data.
// - Six upper memory address lines.
// - Memory address strobe toggles every cycle.
// - Memory output enable low on reads.
// - Memory write enable low on writes.
// - Eight directly reachable host registers.
// - Indirect memory and five further registers.
// - Memory cycles 500 ns, access 250 ns.
module host_port_device
    import host_port_pkg::*;
#(
    parameter int CYCLE_CLKS = `MEM_CYCLE_CLKS,
    parameter int ACCESS_CLKS = `MEM_ACCESS_CLKS
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic resetn,
    // Host bus.
    host_port_if.device hbus,
    // Private memory bus.
    output logic [7:0] mem_low_addr_data_out,
    output logic mem_low_addr_data_oe,
    input wire logic [7:0] mem_low_addr_data_in,
    output logic [5:0] mem_high_addr,
    output logic mem_addr_strobe_n,
    output logic mem_oe_n,
    output logic mem_we_n,
    // Indirect configuration registers as seen by display logic.
    output logic [7:0] page_origin,
    output logic [7:0] char_gen_base,
    output logic [7:0] page_attributes,
    output logic [7:0] margin_attr,
    output logic [7:0] timing_gen_select
);
    // Everything this end holds.
    typedef struct packed {
        logic [1:0] as_s;
        logic [1:0] ds_s;
        logic [1:0] rw_s;
        logic [1:0] cs_s;
        logic [15:0] ad_s;
        logic as_d;
        logic ds_d;
        logic rw_d;
        logic [2:0] addr;
        bus_style_t style;
        logic sel;
        logic wr_done;
        logic [7:0] rd_data;
        logic [7:0][7:0] regs;
        logic [4:0][7:0] ind;
        logic busy;
        logic mem_req;
        logic mem_write;
        logic ind_pending;
    } dev_t;

    dev_t d_reg;
    dev_t d_next;

    logic mem_done;
    logic [7:0] mem_rdata;

    // Synchronised host pins; only the second stage is read.
    logic as_q;
    logic ds_q;
    logic rw_q;
    logic cs_q;
    logic [7:0] ad_q;
    assign as_q = d_reg.as_s[1];
    assign ds_q = d_reg.ds_s[1];
    assign rw_q = d_reg.rw_s[1];
    assign cs_q = d_reg.cs_s[1];
    assign ad_q = d_reg.ad_s[15:8];

    // Read enable window depends on the latched style.
    logic rd_window;
    always_comb begin
        if (d_reg.style == STYLE_DS_HIGH) begin
            rd_window = !ds_q && rw_q;
        end else begin
            rd_window = ds_q && rw_q;
        end
    end

    // Write strobe edge: end of the write pulse in each style.
    logic wr_edge;
    always_comb begin
        if (d_reg.style == STYLE_DS_HIGH) begin
            // Rising rw ends the write pulse; data is stable there.
            wr_edge = rw_q && !d_reg.rw_d;
        end else begin
            // Falling data strobe ends the write with rw low.
            wr_edge = !ds_q && d_reg.ds_d && !rw_q;
        end
    end

    // Register file, capture and command logic.
    always_comb begin
        d_next = d_reg;
        d_next.as_s = {d_reg.as_s[0], hbus.host_addr_strobe};
        d_next.ds_s = {d_reg.ds_s[0], hbus.host_data_strobe};
        d_next.rw_s = {d_reg.rw_s[0], hbus.host_rw};
        d_next.cs_s = {d_reg.cs_s[0], hbus.host_cs_n};
        d_next.ad_s = {d_reg.ad_s[7:0], hbus.host_ad};
        d_next.as_d = as_q;
        d_next.ds_d = ds_q;
        d_next.rw_d = rw_q;
        d_next.mem_req = d_reg.mem_req && !mem_done;
        // Falling address strobe starts a host cycle.
        if (!as_q && d_reg.as_d) begin
            d_next.addr = ad_q[2:0];
            d_next.style = bus_style_t'(ds_q);
            d_next.sel = !cs_q;
            d_next.wr_done = 1'b0;
        end
        // Read data is frozen when the window opens.
        if (!rd_window) begin
            d_next.rd_data = d_reg.regs[d_reg.addr];
            if (d_reg.addr == `REG_CMD_STATUS) begin
                d_next.rd_data = 8'h00;
                d_next.rd_data[`STAT_BUSY] = d_reg.busy;
            end
        end
        // One write per host cycle into the direct registers.
        if (wr_edge && d_reg.sel && !d_reg.wr_done) begin
            d_next.wr_done = 1'b1;
            d_next.regs[d_reg.addr] = ad_q;
            // A command write starts an indirect access.
            if (d_reg.addr == `REG_CMD_STATUS && !d_reg.busy) begin
                d_next.busy = 1'b1;
                case (ad_q)
                    `CMD_MEM_READ: begin
                        d_next.mem_req = 1'b1;
                        d_next.mem_write = 1'b0;
                    end
                    `CMD_MEM_WRITE: begin
                        d_next.mem_req = 1'b1;
                        d_next.mem_write = 1'b1;
                    end
                    `CMD_IND_READ, `CMD_IND_WRITE: begin
                        d_next.ind_pending = 1'b1;
                    end
                    default: begin
                        d_next.busy = 1'b0;
                    end
                endcase
            end
        end
        // Indirect register access finishes in one cycle.
        if (d_reg.ind_pending) begin
            d_next.ind_pending = 1'b0;
            d_next.busy = 1'b0;
            if (d_reg.regs[`REG_DATA_ONE][2:0] <= `IND_TIMING_SEL) begin
                if (d_reg.regs[`REG_CMD_STATUS] == `CMD_IND_WRITE) begin
                    d_next.ind[d_reg.regs[`REG_DATA_ONE][2:0]] =
                        d_reg.regs[`REG_DATA_TWO];
                end else begin
                    d_next.regs[`REG_DATA_TWO] =
                        d_reg.ind[d_reg.regs[`REG_DATA_ONE][2:0]];
                end
            end
        end
        // Memory access completion; read data lands in data_reg_one.
        if (mem_done) begin
            d_next.busy = 1'b0;
            if (!d_reg.mem_write) begin
                d_next.regs[`REG_DATA_ONE] = mem_rdata;
            end
        end
    end

    // Register all state.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            // Address strobe idles low, so its stages reset low and no
            // false fall follows reset.
            d_reg <= '0;
            d_reg.cs_s <= 2'b11;
        end else begin
            d_reg <= d_next;
        end
    end

    // Host bus drive, only for a selected read. Never while the address
    // strobe is up or its fall is being decoded: the host owns the bus
    // then, and the window may still follow the previous cycle's style.
    assign hbus.host_ad_from_dev = d_reg.rd_data;
    assign hbus.host_ad_dev_oe = d_reg.sel && rd_window && !as_q &&
                                 !d_reg.as_d;

    assign page_origin = d_reg.ind[`IND_PAGE_ORIGIN];
    assign char_gen_base = d_reg.ind[`IND_CHAR_GEN_BASE];
    assign page_attributes = d_reg.ind[`IND_PAGE_ATTR];
    assign margin_attr = d_reg.ind[`IND_MARGIN_ATTR];
    assign timing_gen_select = d_reg.ind[`IND_TIMING_SEL];

    // Private memory sequencer; the pointer forms the 14-bit address.
    mem_cycle_gen #(
        .CYCLE_CLKS(CYCLE_CLKS),
        .ACCESS_CLKS(ACCESS_CLKS)
    ) u_mem (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .req(d_reg.mem_req),
        .req_write(d_reg.mem_write),
        .req_addr({d_reg.regs[`REG_MAIN_PTR_HI][5:0],
                   d_reg.regs[`REG_MAIN_PTR_LO]}),
        .req_wdata(d_reg.regs[`REG_DATA_ONE]),
        .done(mem_done),
        .rdata(mem_rdata),
        .mem_low_addr_data_out(mem_low_addr_data_out),
        .mem_low_addr_data_oe(mem_low_addr_data_oe),
        .mem_low_addr_data_in(mem_low_addr_data_in),
        .mem_high_addr(mem_high_addr),
        .mem_addr_strobe_n(mem_addr_strobe_n),
        .mem_oe_n(mem_oe_n),
        .mem_we_n(mem_we_n)
    );
endmodule : host_port_device

// ===== logic/host_port_regs.svh
`ifndef HOST_PORT_REGS_SVH
`define HOST_PORT_REGS_SVH

// Direct register indices, low three bits of the latched host address.
`define REG_CMD_STATUS 3'h0
`define REG_DATA_ONE 3'h1
`define REG_DATA_TWO 3'h2
`define REG_DATA_THREE 3'h3
`define REG_AUX_PTR_HI 3'h4
`define REG_AUX_PTR_LO 3'h5
`define REG_MAIN_PTR_HI 3'h6
`define REG_MAIN_PTR_LO 3'h7

// Command codes written to the command register.
`define CMD_MEM_READ 8'h01
`define CMD_MEM_WRITE 8'h02
`define CMD_IND_READ 8'h03
`define CMD_IND_WRITE 8'h04

// Indirect register indices, low three bits of data_reg_one.
`define IND_PAGE_ORIGIN 3'h0
`define IND_CHAR_GEN_BASE 3'h1
`define IND_PAGE_ATTR 3'h2
`define IND_MARGIN_ATTR 3'h3
`define IND_TIMING_SEL 3'h4

// Status bit positions.
`define STAT_BUSY 7

// Memory cycle timing.
`define MEM_CYCLE_NS 500
`define MEM_ACCESS_NS 250
`define CLK_PERIOD_NS 5
`define MEM_CYCLE_CLKS (`MEM_CYCLE_NS / `CLK_PERIOD_NS)
`define MEM_ACCESS_CLKS (`MEM_ACCESS_NS / `CLK_PERIOD_NS)

// Reset value of every register.
`define REG_RESET 8'h00

`endif

// ===== logic/host_port_pkg.sv
package host_port_pkg;

    // Phase of the private memory cycle.
    typedef enum logic [1:0] {
        MEM_ADDR = 2'b00,
        MEM_DATA = 2'b01,
        MEM_DONE = 2'b11
    } mem_phase_t;

    // Bus style latched at the address strobe.
    typedef enum logic {
        STYLE_DS_LOW = 1'b0,
        STYLE_DS_HIGH = 1'b1
    } bus_style_t;

endpackage : host_port_pkg

// ===== logic/host_port_if.sv
interface host_port_if;
    // Host side pins.
    logic host_addr_strobe;
    logic host_data_strobe;
    logic host_rw;
    logic host_cs_n;
    logic [7:0] host_ad_from_host;
    logic host_ad_host_oe;
    logic [7:0] host_ad_from_dev;
    logic host_ad_dev_oe;

    // The wire level resolved from both enables.
    logic [7:0] host_ad;
    assign host_ad = host_ad_dev_oe ? host_ad_from_dev :
                     host_ad_host_oe ? host_ad_from_host : 8'hFF;

    modport device (
        input host_addr_strobe,
        input host_data_strobe,
        input host_rw,
        input host_cs_n,
        input host_ad,
        output host_ad_from_dev,
        output host_ad_dev_oe
    );

    modport host (
        output host_addr_strobe,
        output host_data_strobe,
        output host_rw,
        output host_cs_n,
        output host_ad_from_host,
        output host_ad_host_oe,
        input host_ad
    );
endinterface : host_port_if

// ===== logic/mem_cycle_gen.sv
`include "host_port_regs.svh"

// Free running private memory cycle sequencer with a request slot.
module mem_cycle_gen
    import host_port_pkg::*;
#(
    parameter int CYCLE_CLKS = `MEM_CYCLE_CLKS,
    parameter int ACCESS_CLKS = `MEM_ACCESS_CLKS
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic resetn,
    // Request from the register file.
    input wire logic req,
    input wire logic req_write,
    input wire logic [13:0] req_addr,
    input wire logic [7:0] req_wdata,
    output logic done,
    output logic [7:0] rdata,
    // Memory pins.
    output logic [7:0] mem_low_addr_data_out,
    output logic mem_low_addr_data_oe,
    input wire logic [7:0] mem_low_addr_data_in,
    output logic [5:0] mem_high_addr,
    output logic mem_addr_strobe_n,
    output logic mem_oe_n,
    output logic mem_we_n
);
    localparam int HALF = CYCLE_CLKS / 2;

    initial begin
        // The read sample point must fall inside the data half.
        if (ACCESS_CLKS < 2 || HALF + ACCESS_CLKS > CYCLE_CLKS ||
            CYCLE_CLKS > 255)
            $error("mem_cycle_gen: unusable cycle timing");
    end

    // All state of the sequencer.
    typedef struct packed {
        logic [7:0] cnt;
        logic active;
        logic write;
        logic [13:0] addr;
        logic [7:0] wdata;
        logic [7:0] rdata;
        logic done;
        logic [7:0] refresh;
        logic [1:0] sync0;
        logic [7:0] sync1;
    } seq_t;

    seq_t s_reg;
    seq_t s_next;

    // Strobe is high in the first half of each cycle: address phase.
    logic addr_phase;
    assign addr_phase = s_reg.cnt < 8'(HALF);

    // Next-state logic for the cycle counter and request slot.
    always_comb begin
        s_next = s_reg;
        s_next.done = 1'b0;
        s_next.sync0 = 2'b00;
        s_next.sync1 = mem_low_addr_data_in;
        if (s_reg.cnt == 8'(CYCLE_CLKS - 1)) begin
            s_next.cnt = 8'h00;
            // Finished access reports back; then a new slot opens.
            if (s_reg.active) begin
                s_next.done = 1'b1;
                s_next.active = 1'b0;
            end else if (req) begin
                s_next.active = 1'b1;
                s_next.write = req_write;
                s_next.addr = req_addr;
                s_next.wdata = req_wdata;
            end else begin
                // Idle slots serve as refresh reads.
                s_next.refresh = s_reg.refresh + 8'h01;
            end
        end else begin
            s_next.cnt = s_reg.cnt + 8'h01;
        end
        // Sample memory data late in the cycle, after the access time.
        if (s_reg.cnt == 8'(HALF + ACCESS_CLKS - 1) && !s_reg.write) begin
            s_next.rdata = s_reg.sync1;
        end
    end

    // Register the sequencer state.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // Pin drive from state.
    always_comb begin
        mem_addr_strobe_n = addr_phase;
        mem_high_addr = s_reg.active ? s_reg.addr[13:8] : 6'h00;
        if (addr_phase) begin
            mem_low_addr_data_out = s_reg.active ? s_reg.addr[7:0]
                                                 : s_reg.refresh;
            mem_low_addr_data_oe = 1'b1;
        end else begin
            mem_low_addr_data_out = s_reg.wdata;
            mem_low_addr_data_oe = s_reg.active && s_reg.write;
        end
        mem_oe_n = addr_phase || (s_reg.active && s_reg.write);
        mem_we_n = addr_phase || !(s_reg.active && s_reg.write);
        done = s_reg.done;
        rdata = s_reg.rdata;
    end
endmodule : mem_cycle_gen

// ===== logic/host_port_master.sv
`include "host_port_regs.svh"

// Host end: runs one register access per request, alternating between
// the data strobe low style and the data strobe high style.
module host_port_master
    import host_port_pkg::*;
#(
    parameter int PHASE_CLKS = 20
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic resetn,
    // Host bus.
    host_port_if.host hbus,
    // User request.
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [2:0] req_addr,
    input wire logic [7:0] req_wdata,
    output logic req_ready,
    output logic rsp_valid,
    output logic [7:0] rsp_rdata
);
    initial begin
        if (PHASE_CLKS < 4 || PHASE_CLKS > 255)
            $error("host_port_master: PHASE_CLKS out of range");
    end

    // All host state.
    typedef struct packed {
        logic [2:0] phase;
        logic [7:0] cnt;
        logic write;
        logic [2:0] addr;
        logic [7:0] wdata;
        logic [7:0] rdata;
        logic rsp;
        logic [15:0] ad_s;
        logic style;
    } hst_t;

    hst_t h_reg;
    hst_t h_next;

    // Phase 0 idle, 1 address, 2 gap, 3 data, 4 recovery.
    always_comb begin
        h_next = h_reg;
        h_next.rsp = 1'b0;
        h_next.ad_s = {h_reg.ad_s[7:0], hbus.host_ad};
        h_next.cnt = h_reg.cnt + 8'h01;
        if (h_reg.phase == 3'd0) begin
            h_next.cnt = 8'h00;
            if (req_valid) begin
                h_next.phase = 3'd1;
                // Each access flips the style so both decodes get used.
                h_next.style = !h_reg.style;
                h_next.write = req_write;
                h_next.addr = req_addr;
                h_next.wdata = req_wdata;
            end
        end else if (h_reg.cnt == 8'(PHASE_CLKS - 1)) begin
            h_next.cnt = 8'h00;
            if (h_reg.phase == 3'd3 && !h_reg.write) begin
                h_next.rdata = h_reg.ad_s[15:8];
            end
            h_next.phase = (h_reg.phase == 3'd4) ? 3'd0 : h_reg.phase + 3'd1;
            h_next.rsp = (h_reg.phase == 3'd4);
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            h_reg <= '0;
        end else begin
            h_reg <= h_next;
        end
    end

    // The data phase of an access.
    logic data_slot;
    assign data_slot = (h_reg.phase == 3'd3);

    // Pin drive; select is held low through the whole access.
    always_comb begin
        hbus.host_addr_strobe = (h_reg.phase == 3'd1);
        if (h_reg.style) begin
            // Strobe high style: strobe low reads, rw low writes.
            hbus.host_data_strobe = !(data_slot && !h_reg.write);
            hbus.host_rw = !(data_slot && h_reg.write);
        end else begin
            // Strobe low style: strobe high carries the transfer.
            hbus.host_data_strobe = data_slot;
            hbus.host_rw = !h_reg.write || h_reg.phase == 3'd0;
        end
        hbus.host_cs_n = (h_reg.phase == 3'd0);
        hbus.host_ad_from_host = (h_reg.phase <= 3'd2) ?
            {5'h00, h_reg.addr} : h_reg.wdata;
        hbus.host_ad_host_oe = (h_reg.phase == 3'd1) ||
            (h_reg.phase == 3'd2) ||
            (h_reg.write && h_reg.phase >= 3'd3);
        req_ready = (h_reg.phase == 3'd0);
        rsp_valid = h_reg.rsp;
        rsp_rdata = h_reg.rdata;
    end
endmodule : host_port_master

// ===== testbench/host_port_asserts.sv
// Watches the host wires and the private memory pins of the device end.
module host_port_asserts (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic resetn,
    // Host bus wires.
    input wire logic host_data_strobe,
    input wire logic host_rw,
    input wire logic host_ad_host_oe,
    input wire logic host_ad_dev_oe,
    // Private memory pins.
    input wire logic mem_low_addr_data_oe,
    input wire logic [5:0] mem_high_addr,
    input wire logic mem_addr_strobe_n,
    input wire logic mem_oe_n,
    input wire logic mem_we_n
);
    // One clock domain, so clocking and reset are given once.
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);

    // Strobe is high for half of each 100 clock memory cycle.
    a_strobe_low_half: assert property (
        $fell(mem_addr_strobe_n) |-> ##50 $rose(mem_addr_strobe_n))
        else $error("memory strobe low half has wrong length");
    a_strobe_high_half: assert property (
        $rose(mem_addr_strobe_n) |-> ##50 $fell(mem_addr_strobe_n))
        else $error("memory strobe high half has wrong length");
    // The low byte carries the address while the strobe is high.
    a_addr_phase_drive: assert property (
        mem_addr_strobe_n |-> mem_low_addr_data_oe)
        else $error("low memory byte undriven in address phase");
    // While the memory outputs data the device must let go of the byte.
    a_read_no_fight: assert property (
        !mem_oe_n |-> !mem_low_addr_data_oe)
        else $error("device drives memory byte during a read");
    a_oe_we_apart: assert property (
        !(!mem_oe_n && !mem_we_n))
        else $error("memory read and write enabled together");
    a_write_in_data: assert property (
        !mem_we_n |-> !mem_addr_strobe_n && mem_low_addr_data_oe)
        else $error("memory write outside a driven data phase");
    // Upper address must not move while the data phase runs.
    a_high_addr_hold: assert property (
        !mem_addr_strobe_n && $past(!mem_addr_strobe_n)
        |-> $stable(mem_high_addr))
        else $error("upper memory address moved in data phase");
    a_no_bus_fight: assert property (
        !(host_ad_dev_oe && host_ad_host_oe))
        else $error("host and device drive the shared bus together");
    // Read drive starts two edges after the data strobe moved, in either
    // style, with read/write high; the synchroniser sets that lag.
    a_read_window: assert property (
        $rose(host_ad_dev_oe)
        |-> $past(host_rw, 2)
            && $past(host_data_strobe, 2) != $past(host_data_strobe, 3))
        else $error("device drove host bus outside a read window");
    // Any strobe move during a drive closes the window.
    a_read_release: assert property (
        host_ad_dev_oe && $changed(host_data_strobe)
        |-> ##[1:4] !host_ad_dev_oe)
        else $error("device kept host bus after the window closed");
endmodule : host_port_asserts

// ===== testbench/muxed_host_and_private_memory_port_test.sv
`include "host_port_regs.svh"

module muxed_host_and_private_memory_port_test;
    timeunit 1ns;
    timeprecision 100ps;

    // User side of the host end.
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic req_valid = 1'b0;
    logic req_write = 1'b0;
    logic [2:0] req_addr = 3'h0;
    logic [7:0] req_wdata = 8'h00;
    logic req_ready;
    logic rsp_valid;
    logic [7:0] rsp_rdata;
    // Private memory pins and a behavioural memory behind them.
    logic [7:0] mem_out;
    logic [7:0] mem_in;
    logic mem_drv;
    logic mem_strobe_n;
    logic mem_oe_n;
    logic mem_we_n;
    logic [5:0] mem_high_addr;
    logic [7:0] low_latch = 8'h00;
    logic [7:0] mem [0:16383];
    logic [7:0] ind_out [0:4];
    // Notes: bit 8 set means the answer is compared with bits 7:0.
    logic [8:0] note_q [$];
    logic [8:0] note;
    logic [7:0] last_rd = 8'h00;
    int n_mismatch = 0;
    int tests_run = 0;
    int seed = 35676;

    // 200 MHz clock.
    always #2.5 sys_clk = ~sys_clk;

    host_port_if hbus_if ();

    host_port_master host_port_master_inst (
        .sys_clk(sys_clk), .resetn(resetn), .hbus(hbus_if),
        .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
        .req_wdata(req_wdata), .req_ready(req_ready),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));

    host_port_device host_port_device_inst (
        .sys_clk(sys_clk), .resetn(resetn), .hbus(hbus_if),
        .mem_low_addr_data_out(mem_out), .mem_low_addr_data_oe(mem_drv),
        .mem_low_addr_data_in(mem_in), .mem_high_addr(mem_high_addr),
        .mem_addr_strobe_n(mem_strobe_n), .mem_oe_n(mem_oe_n),
        .mem_we_n(mem_we_n), .page_origin(ind_out[0]),
        .char_gen_base(ind_out[1]), .page_attributes(ind_out[2]),
        .margin_attr(ind_out[3]), .timing_gen_select(ind_out[4]));

    host_port_asserts host_port_asserts_inst (
        .sys_clk(sys_clk), .resetn(resetn),
        .host_data_strobe(hbus_if.host_data_strobe),
        .host_rw(hbus_if.host_rw),
        .host_ad_host_oe(hbus_if.host_ad_host_oe),
        .host_ad_dev_oe(hbus_if.host_ad_dev_oe),
        .mem_low_addr_data_oe(mem_drv), .mem_high_addr(mem_high_addr),
        .mem_addr_strobe_n(mem_strobe_n), .mem_oe_n(mem_oe_n),
        .mem_we_n(mem_we_n));

    // Clocked latch of the low address byte avoids racing the strobe edge.
    always @(posedge sys_clk) begin
        if (mem_strobe_n) begin
            low_latch <= mem_out;
        end
        if (!mem_we_n) begin
            mem[{mem_high_addr, low_latch}] <= mem_out;
        end
    end
    // An idle memory shows inverted data so stale values cannot pass.
    assign mem_in = !mem_oe_n ? mem[{mem_high_addr, low_latch}] :
                    ~mem[{mem_high_addr, low_latch}];

    // Compares one value and counts the comparison.
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask : check

    // Prints the counts and the verdict, then stops.
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : conclude

    // A wait that ran out counts as a mismatch and ends the run.
    task automatic hang;
        n_mismatch++;
        $display("unexpected hang at %0t", $time);
        conclude();
    endtask : hang

    // Each answer takes the oldest note.
    always @(posedge sys_clk) begin
        if (resetn && rsp_valid === 1'b1) begin
            last_rd = rsp_rdata;
            if (note_q.size() == 0) begin
                hang();
            end else begin
                note = note_q.pop_front();
                if (note[8]) check(rsp_rdata, note[7:0]);
            end
        end
    end

    // One register access; holds the request until it is taken.
    task automatic access(input logic w, input logic [2:0] a,
                          input logic [7:0] d, input logic [8:0] n);
        int i;
        note_q.push_back(n);
        @(posedge sys_clk);
        #1;
        req_valid = 1'b1;
        req_write = w;
        req_addr = a;
        req_wdata = d;
        for (i = 0; i < 1000 && req_ready !== 1'b1; i++) @(negedge sys_clk);
        @(posedge sys_clk);
        #1;
        req_valid = 1'b0;
        for (i = 0; i < 2000 && note_q.size() != 0; i++) @(posedge sys_clk);
        if (note_q.size() != 0) hang();
    endtask : access

    // Reads status until the busy bit clears.
    task automatic poll;
        int i;
        for (i = 0; i < 20; i++) begin
            access(1'b0, `REG_CMD_STATUS, 8'h00, 9'h000);
            if (last_rd[`STAT_BUSY] === 1'b0) break;
        end
        if (i == 20) hang();
    endtask : poll

    // Main sequence: direct, indirect, then memory traffic.
    initial begin
        logic [7:0] v [1:7];
        logic [7:0] d;
        logic [7:0] hi;
        logic [7:0] lo;
        for (int i = 0; i < 16384; i++) mem[i] = 8'($random(seed));
        repeat (20) @(posedge sys_clk);
        #1;
        resetn = 1'b1;
        for (int a = 1; a < 8; a++) begin
            v[a] = 8'($random(seed));
            access(1'b1, 3'(a), v[a], 9'h000);
        end
        for (int a = 1; a < 8; a++) begin
            access(1'b0, 3'(a), 8'h00, {1'b1, v[a]});
        end
        $display("test direct registers done");
        for (int a = 0; a < 5; a++) begin
            d = 8'($random(seed));
            access(1'b1, `REG_DATA_ONE, 8'(a), 9'h000);
            access(1'b1, `REG_DATA_TWO, d, 9'h000);
            access(1'b1, `REG_CMD_STATUS, `CMD_IND_WRITE, 9'h000);
            poll();
            check(ind_out[a], d);
            access(1'b1, `REG_DATA_TWO, ~d, 9'h000);
            access(1'b1, `REG_CMD_STATUS, `CMD_IND_READ, 9'h000);
            poll();
            access(1'b0, `REG_DATA_TWO, 8'h00, {1'b1, d});
        end
        $display("test indirect registers done");
        for (int k = 0; k < 3; k++) begin
            hi = 8'($random(seed));
            lo = 8'($random(seed));
            d = 8'($random(seed));
            access(1'b1, `REG_MAIN_PTR_HI, hi, 9'h000);
            access(1'b1, `REG_MAIN_PTR_LO, lo, 9'h000);
            access(1'b1, `REG_DATA_ONE, d, 9'h000);
            access(1'b1, `REG_CMD_STATUS, `CMD_MEM_WRITE, 9'h000);
            poll();
            check(mem[{hi[5:0], lo}], d);
            mem[{hi[5:0], lo}] = d ^ 8'h5A;
            access(1'b1, `REG_MAIN_PTR_HI, hi, 9'h000);
            access(1'b1, `REG_MAIN_PTR_LO, lo, 9'h000);
            access(1'b1, `REG_CMD_STATUS, `CMD_MEM_READ, 9'h000);
            poll();
            access(1'b0, `REG_DATA_ONE, 8'h00, {1'b1, d ^ 8'h5A});
        end
        $display("test private memory done");
        conclude();
    end
endmodule : muxed_host_and_private_memory_port_test
